// ### core/bridge_cfg_pkg.sv
// Package with offsets, field positions and fixed values of the bridge primary configuration header.
package bridge_cfg_pkg;
   // Byte offsets of the registers inside the configuration header.
   localparam logic [7:0] OFS_PRI_STATUS = 8'h06;
   localparam logic [7:0] OFS_REVISION = 8'h08;
   localparam logic [7:0] OFS_SUB_CLASS = 8'h0a;
   localparam logic [7:0] OFS_BASE_CLASS = 8'h0b;
   localparam logic [7:0] OFS_LATENCY = 8'h0d;
   localparam logic [7:0] OFS_HEADER = 8'h0e;
   localparam logic [7:0] OFS_UP_BUS = 8'h18;
   localparam logic [7:0] OFS_DOWN_BUS = 8'h19;
   // Bit positions inside the primary status register.
   localparam int BIT_SYS_ERR = 14;
   // Fixed read values.
   localparam logic [15:0] PRI_STATUS_FIXED = 16'h00a0;
   localparam logic [7:0] SUB_CLASS_VAL = 8'h04;
   localparam logic [7:0] BASE_CLASS_VAL = 8'h06;
   localparam logic [7:0] HEADER_VAL = 8'h01;
   localparam logic [7:0] UP_BUS_VAL = 8'h00;
   localparam logic [7:0] LATENCY_MASK = 8'hf8;
   localparam logic [7:0] LATENCY_RST = 8'h00;
   localparam logic [7:0] DOWN_BUS_RST = 8'h00;
   // Configuration access request carried as one bundle.
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [15:0] wdata;
      logic [1:0] be;
   } cfg_req_s;
endpackage

// ### core/bridge_primary_config_header.sv
// Bridge primary configuration header register bank.
//
// Function
// - Parity fault seen bit reads zero.
// - System error flag sets on message, write-one-clears.
// - Abort status bits always read zero.
// - Select timing field reads 00b.
// - Data parity seen bit reads zero.
// - Back-to-back capable bit reads one.
// - High speed capable bit reads one.
// - Revision mirrors the main revision register.
// - Sub-class register reads 04h.
// - Latency bits 7:3 scratchpad, 2:0 zero.
// - Header type register reads 01h.
// - Upstream bus number reads 00h always.
// - Downstream bus number writable, routes config cycles.
// - No system error while enable is clear.
`timescale 1ns/1ps
`default_nettype none
module bridge_primary_config_header
   import bridge_cfg_pkg::*;
(
   input wire logic i_core_clk, // Core clock, 200 MHz.
   input wire logic i_rst, // Asynchronous reset, active high.
   input wire cfg_req_s i_req, // Configuration access, one cycle per access.
   input wire logic [7:0] i_main_revision, // Revision of the main function.
   input wire logic i_sys_err_enable, // System error enable from the command register.
   input wire logic i_sys_err_event, // Enabled error condition pulse.
   output logic [15:0] o_rdata, // Read data, valid with o_rvalid.
   output logic o_rvalid, // Read answer strobe.
   output logic o_sys_err_msg, // Pulse: system error message to the upstream hub link.
   output logic [7:0] o_downstream_bus_number // Bus number routed to the streaming link.
);

   // Read decode of the byte-addressed map; unmapped offsets return zero.
   function automatic logic [15:0] read_mux(input logic [7:0] addr, input logic flag,
                                            input logic [7:0] rev, input logic [7:0] lat,
                                            input logic [7:0] dbus);
      logic [15:0] v;
      v = 16'h0000;
      unique case (addr)
         // Bits 15,13,12,11,10:9,8 fixed zero; 7 and 5 fixed one.
         OFS_PRI_STATUS: v = PRI_STATUS_FIXED | {1'b0, flag, 14'h0000};
         OFS_REVISION: v = {8'h00, rev};
         OFS_SUB_CLASS: v = {8'h00, SUB_CLASS_VAL};
         OFS_BASE_CLASS: v = {8'h00, BASE_CLASS_VAL};
         OFS_LATENCY: v = {8'h00, lat & LATENCY_MASK};
         OFS_HEADER: v = {8'h00, HEADER_VAL};
         OFS_UP_BUS: v = {8'h00, UP_BUS_VAL};
         OFS_DOWN_BUS: v = {8'h00, dbus};
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // State of the block. Every register has its next value computed in an always_comb.
   logic sys_err_flag_q; // Signalled system error flag, bit 14 of the status register.
   logic sys_err_flag_d; // Next value of the flag.
   logic msg_q; // Registered system error message pulse.
   logic msg_d; // Next value of the message pulse.
   logic [7:0] lat_q; // Latency scratchpad, low three bits always zero.
   logic [7:0] lat_d; // Next value of the scratchpad.
   logic [7:0] dbus_q; // Downstream bus number.
   logic [7:0] dbus_d; // Next value of the downstream bus number.
   logic [15:0] rdata_q; // Read data register, holds the last answer.
   logic [15:0] rdata_d; // Next value of the read data.
   logic rvalid_q; // Read answer strobe.
   logic rvalid_d; // Next value of the read strobe.

   // Decoded access strobes, shared by the next-state logic and the assertions.
   logic rd_req; // A read is taken on this edge.
   logic wr_low; // A write with the low byte lane enabled.
   logic wr_status; // A write that reaches the flag byte of the status register.
   logic clr_req; // The status write carries a one in the flag position.
   logic msg_now; // An enabled error condition is present.

   // Access decode. Kept apart from the registers so that the assertions can name it.
   always_comb begin
      rd_req = i_req.valid & ~i_req.write; // Reads need no byte enables.
      wr_low = i_req.valid & i_req.write & i_req.be[0]; // Byte registers live in lane 0.
      wr_status = i_req.valid & i_req.write & (i_req.addr == OFS_PRI_STATUS) & i_req.be[1];
      clr_req = wr_status & i_req.wdata[BIT_SYS_ERR];
      // The message is gated here, so a cleared enable can never reach the flag.
      msg_now = i_sys_err_event & i_sys_err_enable;
   end

   // Flag and message next state. The set is applied after the clear, so when an error
   // message and a write of one meet in the same cycle the flag stays set and the new
   // error is not lost; software sees it on its next read and clears it again.
   always_comb begin
      msg_d = msg_now; // One message per enabled event cycle.
      sys_err_flag_d = sys_err_flag_q; // Hold by default.
      if (clr_req) begin
         sys_err_flag_d = 1'b0; // Write of one clears.
      end
      if (msg_now) begin
         sys_err_flag_d = 1'b1; // Set by the message.
      end
   end

   // Flag and message registers.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         sys_err_flag_q <= 1'b0; // Flag is clear after reset.
         msg_q <= 1'b0; // No message during reset.
      end else begin
         sys_err_flag_q <= sys_err_flag_d;
         msg_q <= msg_d;
      end
   end

   // Scratchpad and downstream bus number next state. Both sit in byte lane 0, so a write
   // without the low enable leaves them alone, as do writes to any other offset.
   always_comb begin
      lat_d = lat_q; // Hold by default.
      dbus_d = dbus_q; // Hold by default.
      if (wr_low) begin
         // Only the scratchpad bits are stored; reserved bits drop the write.
         if (i_req.addr == OFS_LATENCY) begin
            lat_d = i_req.wdata[7:0] & LATENCY_MASK;
         end
         // The bus number has no effect here; it leaves on a port for cycle routing.
         if (i_req.addr == OFS_DOWN_BUS) begin
            dbus_d = i_req.wdata[7:0];
         end
      end
   end

   // Scratchpad and bus number registers.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         lat_q <= LATENCY_RST; // Scratchpad reads zero after reset.
         dbus_q <= DOWN_BUS_RST; // No bus assigned until software writes one.
      end else begin
         lat_q <= lat_d;
         dbus_q <= dbus_d;
      end
   end

   // Read answer next state. The data is captured on the request edge, so the flag and the
   // revision are those of that edge; a message in the same cycle shows on the next read.
   always_comb begin
      rvalid_d = rd_req; // Exactly one strobe per read.
      rdata_d = rdata_q; // Hold the last answer between reads.
      if (rd_req) begin
         rdata_d = read_mux(i_req.addr, sys_err_flag_q, i_main_revision, lat_q, dbus_q);
      end
   end

   // Read answer registers.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_q <= 16'h0000; // No answer yet.
         rvalid_q <= 1'b0; // No strobe during reset.
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Every output comes straight from a register.
   assign o_rdata = rdata_q;
   assign o_rvalid = rvalid_q;
   assign o_sys_err_msg = msg_q;
   assign o_downstream_bus_number = dbus_q;

   // Named steps of the checked behaviours.
   // A read of a given offset taken on this edge.
   sequence rd_at(logic [7:0] a);
      i_req.valid && !i_req.write && i_req.addr == a;
   endsequence

   // A low-lane write of a given offset taken on this edge.
   sequence wr_low_at(logic [7:0] a);
      i_req.valid && i_req.write && i_req.be[0] && i_req.addr == a;
   endsequence

   // An enabled error condition on this edge.
   sequence err_event;
      i_sys_err_event && i_sys_err_enable;
   endsequence

   // A write of one to the flag position on this edge.
   sequence clr_write;
      wr_status && i_req.wdata[BIT_SYS_ERR];
   endsequence

   // The flag and the message follow an enabled error condition on the next edge.
   AST_SYS_ERR_SET: assert property (@(posedge i_core_clk) disable iff (i_rst)
      err_event |=> sys_err_flag_q && o_sys_err_msg)
      else $error("System error flag not set by message.");

   // A write of one clears the flag when no new error arrives with it.
   AST_SYS_ERR_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (clr_req && !msg_now) |=> !sys_err_flag_q)
      else $error("System error flag not cleared by write of one.");

   // A clear that meets a new error loses, so the error stays visible.
   AST_SYS_ERR_PRIORITY: assert property (@(posedge i_core_clk) disable iff (i_rst)
      clr_write |=> sys_err_flag_q == $past(msg_now))
      else $error("Clear and message in one cycle handled wrongly.");

   // Without a clear the flag, once set, stays set.
   AST_SYS_ERR_KEEP: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (!clr_req && sys_err_flag_q) |=> sys_err_flag_q)
      else $error("System error flag dropped without a clear.");

   // With the enable cleared nothing raises the flag or sends a message.
   AST_SYS_ERR_HOLD: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (!i_sys_err_enable && !sys_err_flag_q) |=> !sys_err_flag_q && !o_sys_err_msg)
      else $error("System error raised while disabled.");

   // A message only ever follows a cycle in which the enable was set.
   AST_MSG_ONLY_ENABLED: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_sys_err_msg |-> $past(i_sys_err_enable))
      else $error("System error message sent while disabled.");

   // Fixed bits of the status register, flag bit masked out.
   AST_STATUS_FIXED: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(OFS_PRI_STATUS) |=> o_rvalid && (o_rdata & 16'hbfff) == 16'h00a0)
      else $error("Fixed status bits wrong.");

   // The flag bit of a status read shows the flag of the request edge.
   AST_FLAG_READ: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(OFS_PRI_STATUS) |=> o_rdata[14] == $past(sys_err_flag_q))
      else $error("Status flag bit does not show the flag.");

   // The three abort bits read zero.
   AST_ABORTS: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(OFS_PRI_STATUS) |=> o_rdata[13:11] == 3'b000)
      else $error("Abort status bits not zero.");

   // The select timing field reads the fastest code.
   AST_SELECT_TIMING: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(OFS_PRI_STATUS) |=> o_rdata[10:9] == 2'b00)
      else $error("Select timing field not zero.");

   // The data parity bit reads zero.
   AST_DATA_PARITY: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(OFS_PRI_STATUS) |=> !o_rdata[8])
      else $error("Data parity bit not zero.");

   // The back-to-back capability bit reads one.
   AST_BACK_TO_BACK: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(OFS_PRI_STATUS) |=> o_rdata[7])
      else $error("Back-to-back bit not set.");

   // The speed capability bit reads one.
   AST_HIGH_SPEED: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(OFS_PRI_STATUS) |=> o_rdata[5])
      else $error("Speed capability bit not set.");

   // Reserved status bits read zero.
   AST_STATUS_RESERVED: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(OFS_PRI_STATUS) |=> !o_rdata[6] && o_rdata[4:0] == 5'b00000)
      else $error("Reserved status bits not zero.");

   // The revision follows the main revision input of the request edge.
   AST_REVISION: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(OFS_REVISION) |=> o_rdata == {8'h00, $past(i_main_revision)})
      else $error("Revision mirror mismatch.");

   // Sub-class code.
   AST_CLASS: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(OFS_SUB_CLASS) |=> o_rdata == 16'h0004)
      else $error("Sub-class wrong.");

   // Base class code.
   AST_BASE: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(OFS_BASE_CLASS) |=> o_rdata == 16'h0006)
      else $error("Base class wrong.");

   // A scratchpad write read back on the next cycle returns the upper five bits.
   AST_LATENCY: assert property (@(posedge i_core_clk) disable iff (i_rst)
      wr_low_at(OFS_LATENCY) ##1 rd_at(OFS_LATENCY)
      |=> o_rdata == {8'h00, $past(i_req.wdata[7:0], 2) & 8'hf8})
      else $error("Scratchpad readback wrong.");

   // The reserved scratchpad bits never hold a one.
   AST_LAT_RESERVED: assert property (@(posedge i_core_clk) disable iff (i_rst)
      lat_q[2:0] == 3'b000)
      else $error("Reserved scratchpad bits set.");

   // The scratchpad changes only on its own low-lane write.
   AST_LAT_HOLD: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !(wr_low && i_req.addr == OFS_LATENCY) |=> $stable(lat_q))
      else $error("Scratchpad changed without a write.");

   // Header type code.
   AST_HEADER: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(OFS_HEADER) |=> o_rdata == 16'h0001)
      else $error("Header type wrong.");

   // The upstream bus number is always zero.
   AST_UPBUS: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(OFS_UP_BUS) |=> o_rdata == 16'h0000)
      else $error("Upstream bus number not zero.");

   // A low-lane write stores the downstream bus number.
   AST_DOWNBUS: assert property (@(posedge i_core_clk) disable iff (i_rst)
      wr_low_at(OFS_DOWN_BUS) |=> o_downstream_bus_number == $past(i_req.wdata[7:0]))
      else $error("Downstream bus number not stored.");

   // The downstream bus number changes only on its own low-lane write.
   AST_DOWNBUS_HOLD: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !(wr_low && i_req.addr == OFS_DOWN_BUS) |=> $stable(o_downstream_bus_number))
      else $error("Downstream bus number changed without a write.");

   // Offset 07h, outside the map, reads zero.
   AST_UNMAPPED_ZERO: assert property (@(posedge i_core_clk) disable iff (i_rst)
      rd_at(8'h07) |=> o_rdata == 16'h0000)
      else $error("Unmapped offset not zero.");
endmodule
`default_nettype wire

// ### bench/bridge_primary_config_header_bench.sv
// Self-checking bench for the bridge primary configuration header.
`timescale 1ns/1ps
`default_nettype none
module bridge_primary_config_header_bench;
   import bridge_cfg_pkg::*;
   logic i_core_clk, i_rst, sys_err_enable, sys_err_event, rvalid, sys_err_msg;
   cfg_req_s req;
   logic [7:0] main_revision, down_bus;
   logic [15:0] rdata;
   int n_mismatch = 0;
   int samples_checked = 0;
   logic [7:0] ofs [5] = '{OFS_PRI_STATUS, OFS_SUB_CLASS, OFS_BASE_CLASS, OFS_HEADER, OFS_UP_BUS};
   logic [15:0] expv [5] = '{16'h00a0, 16'h0004, 16'h0006, 16'h0001, 16'h0000};
   bridge_primary_config_header bridge_primary_config_header_i (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(req),
      .i_main_revision(main_revision), .i_sys_err_enable(sys_err_enable),
      .i_sys_err_event(sys_err_event), .o_rdata(rdata), .o_rvalid(rvalid),
      .o_sys_err_msg(sys_err_msg), .o_downstream_bus_number(down_bus));
   // The clock runs at 200 MHz.
   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   // Prints the verdict and stops the run.
   task automatic end_sim();
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Compares one value and counts the outcome.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Drives one access 1 ns after an edge; valid stays up so accesses run back to back.
   task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      input logic [1:0] be);
      req = '{valid: 1'b1, write: wr, addr: a, wdata: d, be: be};
      @(posedge i_core_clk);
      #1;
   endtask
   // Reads one register; the answer is registered, so it is seen one edge later.
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      acc(1'b0, a, 16'h0000, 2'b11);
      chk({15'h0000, rvalid}, 16'h0001);
      chk(rdata, exp);
   endtask
   // Raises one error pulse with valid dropped and checks the message pulse.
   task automatic pulse(input logic en, input logic [15:0] exp_msg);
      req.valid = 1'b0;
      sys_err_enable = en;
      sys_err_event = 1'b1;
      @(posedge i_core_clk);
      #1;
      sys_err_event = 1'b0;
      chk({15'h0000, sys_err_msg}, exp_msg);
   endtask
   // A hang is cut short well past the 37 cycles the tests need.
   initial begin
      #5000;
      n_mismatch++;
      end_sim();
   end
   // Main sequence.
   initial begin
      i_rst = 1'b1;
      req = '0;
      main_revision = 8'h5a;
      sys_err_enable = 1'b0;
      sys_err_event = 1'b0;
      repeat (4) @(posedge i_core_clk);
      #1;
      i_rst = 1'b0;
      for (int k = 0; k < 5; k++) rd(ofs[k], expv[k]);
      rd(OFS_REVISION, 16'h005a);
      main_revision = 8'ha5;
      rd(OFS_REVISION, 16'h00a5);
      acc(1'b1, OFS_LATENCY, 16'hffff, 2'b01);
      rd(OFS_LATENCY, 16'h00f8);
      acc(1'b1, OFS_LATENCY, 16'h0000, 2'b10);
      rd(OFS_LATENCY, 16'h00f8);
      acc(1'b1, OFS_UP_BUS, 16'h00ff, 2'b01);
      rd(OFS_UP_BUS, 16'h0000);
      acc(1'b1, OFS_DOWN_BUS, 16'h003c, 2'b01);
      chk({15'h0000, rvalid}, 16'h0000);
      rd(OFS_DOWN_BUS, 16'h003c);
      chk({8'h00, down_bus}, 16'h003c);
      acc(1'b1, OFS_PRI_STATUS, 16'hffff, 2'b11);
      rd(OFS_PRI_STATUS, 16'h00a0);
      pulse(1'b0, 16'h0000);
      rd(OFS_PRI_STATUS, 16'h00a0);
      pulse(1'b1, 16'h0001);
      rd(OFS_PRI_STATUS, 16'h40a0);
      acc(1'b1, OFS_PRI_STATUS, 16'hbfff, 2'b11);
      rd(OFS_PRI_STATUS, 16'h40a0);
      acc(1'b1, OFS_PRI_STATUS, 16'h4000, 2'b01);
      rd(OFS_PRI_STATUS, 16'h40a0);
      acc(1'b1, OFS_PRI_STATUS, 16'h4000, 2'b10);
      rd(OFS_PRI_STATUS, 16'h00a0);
      rd(8'h07, 16'h0000);
      sys_err_event = 1'b1;
      acc(1'b1, OFS_PRI_STATUS, 16'h4000, 2'b10);
      sys_err_event = 1'b0;
      rd(OFS_PRI_STATUS, 16'h40a0);
      i_rst = 1'b1;
      @(posedge i_core_clk);
      #1;
      i_rst = 1'b0;
      chk({8'h00, down_bus}, 16'h0000);
      rd(OFS_PRI_STATUS, 16'h00a0);
      rd(OFS_LATENCY, 16'h0000);
      end_sim();
   end
endmodule
`default_nettype wire
